// File: besm_bridge_err.sv
// bridge error status latching and system-error reporting, top level
//
// Behaviour
// - downstream master time-out discard sets status bit 0, may report primary
// - downstream delayed read dropped after retry limit sets bit 1
// - downstream delayed write dropped after retry limit sets bit 2
// - downstream posted write dropped after retry limit sets bit 3
// - upstream master time-out discard sets bit 8, may report secondary
// - upstream delayed read dropped after retry limit sets bit 9
// - upstream delayed write dropped after retry limit sets bit 10
// - upstream posted write dropped after retry limit sets bit 11
// - flags reset to zero, stay set, clear only on write of one
// - status bits 7:4, 15:12 and mask bit 7 read zero, ignore writes
// - report only with global enable set and own mask bit clear
// - primary mask bit zero allows report, one suppresses it
// - primary mask bits 0..3 gate downstream discards, not status latching
// - primary mask bit 4 gates secondary target abort on posted write
// - primary mask bit 5 gates secondary master abort on posted write
// - primary mask bit 6 gates secondary parity error on posted write
// - masks loadable by serial ROM preload or by configuration writes from either interface
// - status at 0xd0, primary mask 0xd4, same from both interfaces
// - secondary mask at 0xd5 gates upstream events; bit 0 time-out
`timescale 1ns/1ns
`default_nettype none
`include "besm_params.svh"
module besm_bridge_err
    import besm_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // downstream error events, one-cycle pulses
    input  wire logic        dsMstTimeout,
    input  wire logic        dsReadDiscard,
    input  wire logic        dsWriteDiscard,
    input  wire logic        dsPostedDiscard,
    input  wire logic        dsTargetAbort,
    input  wire logic        dsMasterAbort,
    input  wire logic        dsParityErr,
    // upstream error events, one-cycle pulses
    input  wire logic        usMstTimeout,
    input  wire logic        usReadDiscard,
    input  wire logic        usWriteDiscard,
    input  wire logic        usPostedDiscard,
    input  wire logic        usTargetAbort,
    input  wire logic        usMasterAbort,
    input  wire logic        usParityErr,
    // global system-error enables of each interface
    input  wire logic        pSerrEnable,
    input  wire logic        sSerrEnable,
    // primary interface configuration port
    input  wire logic        pCfgWrEn,
    input  wire logic        pCfgRdEn,
    input  wire besm_byte_t  pCfgAddr,
    input  wire logic [3:0]  pCfgByteEn,
    input  wire besm_dword_t pCfgWrData,
    output besm_dword_t      pCfgRdData,
    output logic             pCfgRdValid,
    // secondary interface configuration port
    input  wire logic        sCfgWrEn,
    input  wire logic        sCfgRdEn,
    input  wire besm_byte_t  sCfgAddr,
    input  wire logic [3:0]  sCfgByteEn,
    input  wire besm_dword_t sCfgWrData,
    output besm_dword_t      sCfgRdData,
    output logic             sCfgRdValid,
    // serial ROM preload of the mask bytes
    input  wire logic        preloadWe,
    input  wire besm_sel_t   preloadSel,
    input  wire besm_byte_t  preloadData,
    // system-error outputs, active low
    output logic             pSerrN,
    output logic             sSerrN
);

    // offsets as wires so their dword index can be sliced
    besm_byte_t  statusOfs;
    besm_byte_t  pmaskOfs;
    besm_byte_t  defMask;
    assign statusOfs = `BESM_STATUS_OFS;
    assign pmaskOfs  = `BESM_PMASK_OFS;
    assign defMask   = `BESM_MASK_DEFINED;

    // event vectors, bit order follows the mask layout
    besm_evt_t   dsEvt;
    besm_evt_t   usEvt;
    assign dsEvt = {dsParityErr, dsMasterAbort, dsTargetAbort,
                    dsPostedDiscard, dsWriteDiscard, dsReadDiscard,
                    dsMstTimeout};
    assign usEvt = {usParityErr, usMasterAbort, usTargetAbort,
                    usPostedDiscard, usWriteDiscard, usReadDiscard,
                    usMstTimeout};

    // address decode, the same map on both interfaces
    logic        pHitStatus;
    logic        pHitMask;
    logic        sHitStatus;
    logic        sHitMask;
    assign pHitStatus = (pCfgAddr[7:2] == statusOfs[7:2]);
    assign pHitMask   = (pCfgAddr[7:2] == pmaskOfs[7:2]);
    assign sHitStatus = (sCfgAddr[7:2] == statusOfs[7:2]);
    assign sHitMask   = (sCfgAddr[7:2] == pmaskOfs[7:2]);

    // write-one-to-clear strobes from both interfaces
    besm_grp_t   dsClr;
    besm_grp_t   usClr;
    logic        pStWr;
    logic        sStWr;
    assign pStWr = pCfgWrEn & pHitStatus;
    assign sStWr = sCfgWrEn & sHitStatus;
    // reserved status bits have no storage, so their writes vanish
    assign dsClr = ({4{pStWr & pCfgByteEn[0]}} & pCfgWrData[3:0])
                 | ({4{sStWr & sCfgByteEn[0]}} & sCfgWrData[3:0]);
    assign usClr = ({4{pStWr & pCfgByteEn[1]}} & pCfgWrData[11:8])
                 | ({4{sStWr & sCfgByteEn[1]}} & sCfgWrData[11:8]);

    // sticky flags; mask bits never reach these set inputs
    besm_grp_t   dsFlags;
    besm_grp_t   usFlags;

    // bits 0..3 from downstream discards
    besm_sticky_flags #(
        .W       (`BESM_GRP_W)
    ) u_dsFlags (
        .ref_clk (ref_clk),
        .srst    (srst),
        .setIn   (dsEvt[3:0]),
        .clrIn   (dsClr),
        .flags_q (dsFlags)
    );

    // bits 8..11 from upstream discards
    besm_sticky_flags #(
        .W       (`BESM_GRP_W)
    ) u_usFlags (
        .ref_clk (ref_clk),
        .srst    (srst),
        .setIn   (usEvt[3:0]),
        .clrIn   (usClr),
        .flags_q (usFlags)
    );

    logic [15:0] statusWord;
    // reserved nibbles read as zero
    assign statusWord = {4'h0, usFlags, 4'h0, dsFlags};

    // mask registers: preload first, then primary, then secondary port
    besm_byte_t  pMask_q;
    besm_byte_t  pMask_d;
    besm_byte_t  sMask_q;
    besm_byte_t  sMask_d;
    logic        pMkWrP;
    logic        pMkWrS;
    logic        sMkWrP;
    logic        sMkWrS;
    logic        preP;
    logic        preS;
    assign pMkWrP = pCfgWrEn & pHitMask & pCfgByteEn[0];
    assign pMkWrS = sCfgWrEn & sHitMask & sCfgByteEn[0];
    assign sMkWrP = pCfgWrEn & pHitMask & pCfgByteEn[1];
    assign sMkWrS = sCfgWrEn & sHitMask & sCfgByteEn[1];
    // the ROM loads before host configuration, so it rarely collides
    assign preP   = preloadWe & (preloadSel == BESM_SEL_PRI);
    assign preS   = preloadWe & (preloadSel == BESM_SEL_SEC);

    // bit 7 is masked off so it always reads zero
    assign pMask_d = defMask & (preP   ? preloadData      :
                                pMkWrP ? pCfgWrData[7:0]  :
                                pMkWrS ? sCfgWrData[7:0]  : pMask_q);
    // secondary mask at byte 0xd5, byte lane 1 of the 0xd4 dword
    assign sMask_d = defMask & (preS   ? preloadData      :
                                sMkWrP ? pCfgWrData[15:8] :
                                sMkWrS ? sCfgWrData[15:8] : sMask_q);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pMask_q <= `BESM_MASK_RST;
            sMask_q <= `BESM_MASK_RST;
        end else begin
            pMask_q <= pMask_d;
            sMask_q <= sMask_d;
        end
    end

    // read multiplexers; unmapped offsets return zero
    besm_dword_t maskWord;
    besm_dword_t pRdSel;
    besm_dword_t sRdSel;
    assign maskWord = {16'h0000, sMask_q, pMask_q};
    assign pRdSel = pHitStatus ? {16'h0000, statusWord} :
                    pHitMask   ? maskWord : `BESM_DWORD_ZERO;
    assign sRdSel = sHitStatus ? {16'h0000, statusWord} :
                    sHitMask   ? maskWord : `BESM_DWORD_ZERO;

    // registered read answer, one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pCfgRdData  <= `BESM_DWORD_ZERO;
            sCfgRdData  <= `BESM_DWORD_ZERO;
            pCfgRdValid <= 1'b0;
            sCfgRdValid <= 1'b0;
        end else begin
            pCfgRdData  <= pCfgRdEn ? pRdSel : `BESM_DWORD_ZERO;
            sCfgRdData  <= sCfgRdEn ? sRdSel : `BESM_DWORD_ZERO;
            pCfgRdValid <= pCfgRdEn;
            sCfgRdValid <= sCfgRdEn;
        end
    end

    // downstream events report on the primary side
    besm_err_report u_pReport (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .evtIn     (dsEvt),
        .maskIn    (pMask_q[6:0]),
        .enableIn  (pSerrEnable),
        .reportN_q (pSerrN)
    );

    // upstream events report on the secondary side
    besm_err_report u_sReport (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .evtIn     (usEvt),
        .maskIn    (sMask_q[6:0]),
        .enableIn  (sSerrEnable),
        .reportN_q (sSerrN)
    );

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    logic pQual;
    logic sQual;
    assign pQual = pSerrEnable & |(dsEvt & ~pMask_q[6:0]);
    assign sQual = sSerrEnable & |(usEvt & ~sMask_q[6:0]);

    property p_dsTimeoutSets;
        dsMstTimeout |=> statusWord[0];
    endproperty
    a_dsTimeoutSets: assert property (p_dsTimeoutSets)
        else $error("status bit 0 not set by downstream time-out");

    property p_dsRetrySets;
        dsReadDiscard || dsWriteDiscard || dsPostedDiscard |=>
            (statusWord[3:1] & $past(dsEvt[3:1])) == $past(dsEvt[3:1]);
    endproperty
    a_dsRetrySets: assert property (p_dsRetrySets)
        else $error("downstream discard flag not set");

    property p_usSets;
        |usEvt[3:0] |=>
            (statusWord[11:8] & $past(usEvt[3:0])) == $past(usEvt[3:0]);
    endproperty
    a_usSets: assert property (p_usSets)
        else $error("upstream discard flag not set");

    property p_flagHolds;
        statusWord[0] && !dsClr[0] |=> statusWord[0];
    endproperty
    a_flagHolds: assert property (p_flagHolds)
        else $error("status flag dropped without a clear");

    property p_flagClears;
        usClr[0] && !usMstTimeout |=> !statusWord[8];
    endproperty
    a_flagClears: assert property (p_flagClears)
        else $error("write of one failed to clear status flag");

    property p_reservedZero;
        pCfgRdEn && pHitStatus |=>
            pCfgRdData[7:4] == 4'h0 && pCfgRdData[15:12] == 4'h0;
    endproperty
    a_reservedZero: assert property (p_reservedZero)
        else $error("reserved status bits read nonzero");

    property p_maskBit7;
        pMkWrP && pCfgWrData[7] |=> !pMask_q[7];
    endproperty
    a_maskBit7: assert property (p_maskBit7)
        else $error("reserved mask bit took a write");

    property p_noEnableNoReport;
        !pSerrEnable |=> pSerrN;
    endproperty
    a_noEnableNoReport: assert property (p_noEnableNoReport)
        else $error("primary report without global enable");

    property p_maskSuppress;
        dsEvt == 7'h01 && pMask_q[0] |=> pSerrN;
    endproperty
    a_maskSuppress: assert property (p_maskSuppress)
        else $error("masked downstream time-out reported");

    property p_pPulse;
        pQual ##1 !pQual |-> !pSerrN ##1 pSerrN;
    endproperty
    a_pPulse: assert property (p_pPulse)
        else $error("primary report is not a one-cycle low pulse");

    property p_sReport;
        sQual |=> !sSerrN;
    endproperty
    a_sReport: assert property (p_sReport)
        else $error("qualified upstream event not reported");

    property p_sMaskSuppress;
        usEvt == 7'h01 && sMask_q[0] |=> sSerrN;
    endproperty
    a_sMaskSuppress: assert property (p_sMaskSuppress)
        else $error("masked upstream time-out reported");

    property p_preload;
        preP |=> pMask_q == ($past(preloadData) & defMask);
    endproperty
    a_preload: assert property (p_preload)
        else $error("serial ROM preload not taken by primary mask");

    property p_sameMap;
        sCfgRdEn && sHitStatus |=>
            sCfgRdData[15:0] == $past(statusWord);
    endproperty
    a_sameMap: assert property (p_sameMap)
        else $error("secondary read of status returned wrong value");

    property p_rdIdleZero;
        !pCfgRdEn |=> !pCfgRdValid && pCfgRdData == `BESM_DWORD_ZERO;
    endproperty
    a_rdIdleZero: assert property (p_rdIdleZero)
        else $error("primary read answer without a read request");

    property p_tgtAbortMask;
        dsEvt == 7'h10 && pSerrEnable && !pMask_q[4] |=> !pSerrN;
    endproperty
    a_tgtAbortMask: assert property (p_tgtAbortMask)
        else $error("unmasked target abort not reported");

    c_pReport:  cover property (pQual ##1 !pSerrN);
    c_sReport:  cover property (sQual ##1 !sSerrN);
    c_clear:    cover property (statusWord[0] ##1 dsClr[0] ##1 !statusWord[0]);
    c_preload:  cover property (preS ##1 sMask_q != 8'h00);

endmodule
`default_nettype wire

// File: besm_bridge_err_bench.sv
// self-checking bench of the bridge error status and mask block
`timescale 1ns/1ns
`default_nettype none
module besm_bridge_err_bench
    import besm_pkg::*;
;
    logic ref_clk, srst, pSerrEnable, sSerrEnable, preloadWe, pSerrN, sSerrN;
    logic [13:0] evt;
    besm_sel_t   preloadSel;
    besm_byte_t  preloadData, pA, sA;
    logic        pWe, pRe, pV, sWe, sRe, sV;
    logic [3:0]  pBe, sBe;
    besm_dword_t pWd, pRd, sWd, sRd;
    int          n_fail, compares, cycles;

    besm_bridge_err DUT (.ref_clk(ref_clk), .srst(srst),
        .dsMstTimeout(evt[0]), .dsReadDiscard(evt[1]),
        .dsWriteDiscard(evt[2]), .dsPostedDiscard(evt[3]),
        .dsTargetAbort(evt[4]), .dsMasterAbort(evt[5]),
        .dsParityErr(evt[6]), .usMstTimeout(evt[7]),
        .usReadDiscard(evt[8]), .usWriteDiscard(evt[9]),
        .usPostedDiscard(evt[10]), .usTargetAbort(evt[11]),
        .usMasterAbort(evt[12]), .usParityErr(evt[13]),
        .pSerrEnable(pSerrEnable), .sSerrEnable(sSerrEnable),
        .pCfgWrEn(pWe), .pCfgRdEn(pRe), .pCfgAddr(pA), .pCfgByteEn(pBe),
        .pCfgWrData(pWd), .pCfgRdData(pRd), .pCfgRdValid(pV),
        .sCfgWrEn(sWe), .sCfgRdEn(sRe), .sCfgAddr(sA), .sCfgByteEn(sBe),
        .sCfgWrData(sWd), .sCfgRdData(sRd), .sCfgRdValid(sV),
        .preloadWe(preloadWe), .preloadSel(preloadSel),
        .preloadData(preloadData), .pSerrN(pSerrN), .sSerrN(sSerrN));
    besm_host_model pHost (.ref_clk(ref_clk), .cfgWrEn(pWe), .cfgRdEn(pRe),
        .cfgAddr(pA), .cfgByteEn(pBe), .cfgWrData(pWd),
        .cfgRdData(pRd), .cfgRdValid(pV));
    besm_host_model sHost (.ref_clk(ref_clk), .cfgWrEn(sWe), .cfgRdEn(sRe),
        .cfgAddr(sA), .cfgByteEn(sBe), .cfgWrData(sWd),
        .cfgRdData(sRd), .cfgRdValid(sV));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // the whole run needs well under two thousand cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input besm_dword_t seen, input besm_dword_t exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic acc(input bit port, input logic wr, input besm_byte_t a,
                       input logic [3:0] be, input besm_dword_t d,
                       output besm_dword_t rd);
        logic ok;
        if (port)
            sHost.access(wr, a, be, d, rd, ok);
        else
            pHost.access(wr, a, be, d, rd, ok);
        check({31'h0, ok}, 32'h1);
    endtask

    task automatic rdChk(input bit port, input besm_byte_t a,
                         input besm_dword_t exp);
        besm_dword_t rd;
        acc(port, 1'b0, a, 4'h0, 32'h0, rd);
        check(rd, exp);
    endtask

    task automatic wr(input bit port, input besm_byte_t a,
                      input logic [3:0] be, input besm_dword_t d);
        besm_dword_t rd;
        acc(port, 1'b1, a, be, d, rd);
    endtask

    // one event pulse, then the report levels of both outputs
    task automatic fire(input int idx, input logic expP, input logic expS);
        @(posedge ref_clk);
        evt <= 14'h1 << idx;
        @(posedge ref_clk);
        evt <= 14'h0;
        #1;
        check({31'h0, pSerrN}, {31'h0, expP});
        check({31'h0, sSerrN}, {31'h0, expS});
        @(posedge ref_clk);
        #1;
        check({30'h0, pSerrN, sSerrN}, 32'h3);
    endtask

    task automatic t_reset();
        for (int p = 0; p < 2; p++) begin
            rdChk(p[0], 8'hd0, 32'h0);
            rdChk(p[0], 8'hd4, 32'h0);
            rdChk(p[0], 8'hd8, 32'h0);
        end
    endtask

    task automatic t_events();
        for (int i = 0; i < 14; i++)
            fire(i, i >= 7, i < 7);
        rdChk(0, 8'hd0, 32'h0f0f);
        rdChk(1, 8'hd0, 32'h0f0f);
        wr(0, 8'hd0, 4'hf, 32'h0);
        rdChk(0, 8'hd0, 32'h0f0f);
        wr(1, 8'hd0, 4'h1, 32'hffff_fff5);
        rdChk(0, 8'hd0, 32'h0f0a);
        wr(0, 8'hd0, 4'h2, 32'h0000_0500);
        rdChk(1, 8'hd0, 32'h0a0a);
        wr(0, 8'hd0, 4'hf, 32'hffff_ffff);
        rdChk(0, 8'hd0, 32'h0);
    endtask

    task automatic t_mask();
        wr(0, 8'hd4, 4'h1, 32'hffff_ffff);
        rdChk(1, 8'hd4, 32'h7f);
        wr(1, 8'hd4, 4'h2, 32'h0000_ff00);
        rdChk(0, 8'hd4, 32'h7f7f);
        for (int i = 0; i < 7; i++) begin
            wr(0, 8'hd4, 4'h3, (32'h101 << i));
            fire(i, 1'b1, 1'b1);
            fire((i + 1) % 7, 1'b0, 1'b1);
            fire(7 + i, 1'b1, 1'b1);
            fire(7 + (i + 1) % 7, 1'b1, 1'b0);
        end
        rdChk(0, 8'hd0, 32'h0f0f);
        wr(0, 8'hd0, 4'h3, 32'hffff);
        wr(1, 8'hd4, 4'h3, 32'h0);
    endtask

    task automatic t_enable();
        @(posedge ref_clk);
        pSerrEnable <= 1'b0;
        fire(0, 1'b1, 1'b1);
        fire(7, 1'b1, 1'b0);
        @(posedge ref_clk);
        sSerrEnable <= 1'b0;
        fire(7, 1'b1, 1'b1);
        rdChk(0, 8'hd0, 32'h0101);
        @(posedge ref_clk);
        pSerrEnable <= 1'b1;
        sSerrEnable <= 1'b1;
        wr(0, 8'hd0, 4'h3, 32'h0101);
    endtask

    task automatic preload(input logic [1:0] sel, input besm_byte_t d);
        @(posedge ref_clk);
        preloadWe   <= 1'b1;
        preloadSel  <= besm_sel_t'(sel);
        preloadData <= d;
        @(posedge ref_clk);
        preloadWe   <= 1'b0;
    endtask

    task automatic t_preload();
        preload(2'b01, 8'hd5);
        preload(2'b10, 8'h3c);
        preload(2'b11, 8'h00);
        rdChk(1, 8'hd4, 32'h3c55);
        fire(0, 1'b1, 1'b1);
        fire(1, 1'b0, 1'b1);
        fire(9, 1'b1, 1'b1);
        fire(7, 1'b1, 1'b0);
    endtask

    initial begin
        n_fail = 0;
        compares = 0;
        cycles = 0;
        srst = 1'b1;
        evt = 14'h0;
        pSerrEnable = 1'b1;
        sSerrEnable = 1'b1;
        preloadWe = 1'b0;
        preloadSel = BESM_SEL_PRI;
        preloadData = 8'h00;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_events();
        t_mask();
        t_enable();
        t_preload();
        // second reset in mid-run with flags and masks set
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        summarize();
    end
endmodule
`default_nettype wire

// File: besm_err_report.sv
// gates error events by enable and mask into an active-low report pulse
`timescale 1ns/1ns
`default_nettype none
`include "besm_params.svh"
module besm_err_report
    import besm_pkg::*;
(
    // clock and reset
    input  wire logic      ref_clk,
    input  wire logic      srst,
    // events, mask and global enable
    input  wire besm_evt_t evtIn,
    input  wire besm_evt_t maskIn,
    input  wire logic      enableIn,
    // report output, active low
    output logic           reportN_q
);

    logic unmasked;
    logic reportN_d;

    // a one in the mask suppresses, a zero lets the event through
    assign unmasked  = |(evtIn & ~maskIn);
    // report needs the global enable and a clear mask bit
    assign reportN_d = ~(enableIn & unmasked);

    // one low cycle per qualifying event pulse
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reportN_q <= 1'b1;
        end else begin
            reportN_q <= reportN_d;
        end
    end

endmodule
`default_nettype wire

// File: besm_host_model.sv
// host software model: configuration master on one bridge interface
`timescale 1ns/1ns
`default_nettype none
module besm_host_model
    import besm_pkg::*;
(
    // clock
    input  wire logic        ref_clk,
    // configuration port, master side
    output logic             cfgWrEn,
    output logic             cfgRdEn,
    output besm_byte_t       cfgAddr,
    output logic [3:0]       cfgByteEn,
    output besm_dword_t      cfgWrData,
    input  wire besm_dword_t cfgRdData,
    input  wire logic        cfgRdValid
);
    initial begin
        cfgWrEn   = 1'b0;
        cfgRdEn   = 1'b0;
        cfgAddr   = 8'h00;
        cfgByteEn = 4'h0;
        cfgWrData = 32'h0;
    end

    // released lines toggle so a late sample never sees the held value
    task automatic access(input logic wr, input besm_byte_t a,
                          input logic [3:0] be, input besm_dword_t d,
                          output besm_dword_t rd, output logic ok);
        rd = 32'h0;
        ok = wr;
        @(posedge ref_clk);
        cfgWrEn   <= wr;
        cfgRdEn   <= ~wr;
        cfgAddr   <= a;
        cfgByteEn <= be;
        cfgWrData <= d;
        @(posedge ref_clk);
        cfgWrEn   <= 1'b0;
        cfgRdEn   <= 1'b0;
        cfgAddr   <= ~a;
        cfgByteEn <= ~be;
        cfgWrData <= ~d;
        if (!wr) begin
            // answer stands from the taking edge, for one cycle
            #1;
            if (cfgRdValid === 1'b1) begin
                rd = cfgRdData;
                ok = 1'b1;
            end
        end
    endtask
endmodule
`default_nettype wire

// File: besm_params.svh
// constants for the bridge error status and error-report mask block
`ifndef BESM_PARAMS_SVH
`define BESM_PARAMS_SVH

// configuration byte offsets, identical from both bus interfaces
`define BESM_STATUS_OFS    8'hd0
`define BESM_PMASK_OFS     8'hd4
`define BESM_SMASK_OFS     8'hd5

// field layout
`define BESM_GRP_W         4
`define BESM_EVT_W         7
`define BESM_ST_DS_LSB     0
`define BESM_ST_US_LSB     8
`define BESM_BYTE_W        8

// reset values
`define BESM_STATUS_RST    16'h0000
`define BESM_MASK_RST      8'h00
`define BESM_DWORD_ZERO    32'h0000_0000

// writable bits of each mask byte; bit 7 is reserved
`define BESM_MASK_DEFINED  8'h7f

// retry count after which the bridge discards a transaction (log2)
`define BESM_RETRY_LOG2    24

`endif

// File: besm_pkg.sv
// types shared by the bridge error status and mask block
package besm_pkg;

    typedef logic [6:0]  besm_evt_t;
    typedef logic [3:0]  besm_grp_t;
    typedef logic [7:0]  besm_byte_t;
    typedef logic [31:0] besm_dword_t;

    // target of a serial-ROM preload write
    typedef enum logic [1:0] {
        BESM_SEL_PRI = 2'b01,
        BESM_SEL_SEC = 2'b10
    } besm_sel_t;

endpackage

// File: besm_sticky_flags.sv
// group of sticky status flags, set by hardware, cleared by writing one
`timescale 1ns/1ns
`default_nettype none
`include "besm_params.svh"
module besm_sticky_flags
    import besm_pkg::*;
#(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         srst,
    // set pulses and write-one-to-clear strobes
    input  wire logic [W-1:0] setIn,
    input  wire logic [W-1:0] clrIn,
    // flag state
    output logic      [W-1:0] flags_q
);

    logic [W-1:0] flags_d;

    // set wins over a clear landing in the same cycle
    assign flags_d = (flags_q & ~clrIn) | setIn;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule
`default_nettype wire
